// ===== cpif_core.v
// main processor side sequencer for conditional trap and context save/restore
// assumes APB master on ref_clk; COPROC_INTERFACE_REGISTER and memory ports answer with same-clock acks
//
// The address map and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "cpif_regs.vh"

module cpif_core
(
   input  wire        ref_clk,
   input  wire        sys_rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output wire        pready,
   output wire        pslverr,
   output reg  [31:0] prdata,
   output wire        cirReq,
   output reg         cirWrite,
   output reg  [2:0]  cirSel,
   output reg  [31:0] cirWdata,
   input  wire        cirAck,
   input  wire [31:0] cirRdata,
   output wire        memReq,
   output reg         memWrite,
   output reg         memLong,
   output reg  [31:0] memAddr,
   output reg  [31:0] memWdata,
   input  wire        memAck,
   input  wire [31:0] memRdata,
   output wire        irqService,
   input  wire        irqDone,
   output reg         trapStart,
   output reg         fmtErrStart
);

////////////////////////////////////////////////////////////////////////////////
localparam [16:0] S_IDLE   = 17'h00001;
localparam [16:0] S_FETCHC = 17'h00002;
localparam [16:0] S_WCOND  = 17'h00004;
localparam [16:0] S_RRESP  = 17'h00008;
localparam [16:0] S_FETCHX = 17'h00010;
localparam [16:0] S_WOPX   = 17'h00020;
localparam [16:0] S_SRD    = 17'h00040;
localparam [16:0] S_SIRQ   = 17'h00080;
localparam [16:0] S_SWFMT  = 17'h00100;
localparam [16:0] S_SROP   = 17'h00200;
localparam [16:0] S_SWMEM  = 17'h00400;
localparam [16:0] S_RMFMT  = 17'h00800;
localparam [16:0] S_RWFMT  = 17'h01000;
localparam [16:0] S_RRD    = 17'h02000;
localparam [16:0] S_RMRD   = 17'h04000;
localparam [16:0] S_RWOP   = 17'h08000;
localparam [16:0] S_ABORT  = 17'h10000;

reg  [16:0] state_q;
reg  [2:0]  opmode_q;
reg  [31:0] instr_q;
reg  [31:0] ea_q;
reg  [31:0] nextPc_q;
reg  [15:0] lastFmt_q;
reg  [31:0] addr_q;
reg  [31:0] scan_q;
reg  [5:0]  cnt_q;
reg  [1:0]  opWords_q;
reg         emptyHit_q;
reg         done_q;
reg         trap_q;
reg         badOp_q;
reg         fmtErr_q;
reg         empty_q;
reg  [31:0] rdMux;
reg         mapped;

wire        apbWr;
wire        apbSetup;
wire        startTrap;
wire        startSave;
wire        startRest;
wire [15:0] decIn;
wire        isEmpty;
wire        isNotReady;
wire        isInvalid;
wire        isValid;
wire        lenOk;
wire        opmodeOk;
wire [1:0]  opWords;
wire        idle;
wire [31:0] status;

////////////////////////////////////////////////////////////////////////////////
// apb slave, zero wait states; read data latched in the setup cycle
assign pready   = psel & penable;
assign pslverr  = pready & ~mapped;
assign apbWr    = pready & pwrite;
assign apbSetup = psel & ~penable;
assign idle     = (state_q == S_IDLE);
// commands while busy are dropped so a running frame is never torn
assign startTrap = apbWr & (paddr == `CPIF_OFF_CMD) & idle & pwdata[`CPIF_CMD_TRAP];
assign startSave = apbWr & (paddr == `CPIF_OFF_CMD) & idle & pwdata[`CPIF_CMD_SAVE]
                   & ~pwdata[`CPIF_CMD_TRAP];
assign startRest = apbWr & (paddr == `CPIF_OFF_CMD) & idle & pwdata[`CPIF_CMD_RESTORE]
                   & ~pwdata[`CPIF_CMD_TRAP] & ~pwdata[`CPIF_CMD_SAVE];

assign status = {26'h0, empty_q, fmtErr_q, badOp_q, trap_q, done_q, ~idle};

always @*
begin
   mapped = 1'b1;
   rdMux  = 32'h0000_0000;
   if (paddr == `CPIF_OFF_CMD)
      rdMux = 32'h0000_0000;
   else if (paddr == `CPIF_OFF_OPMODE)
      rdMux = {29'h0, opmode_q};
   else if (paddr == `CPIF_OFF_INSTR)
      rdMux = instr_q;
   else if (paddr == `CPIF_OFF_EA)
      rdMux = ea_q;
   else if (paddr == `CPIF_OFF_STATUS)
      rdMux = status;
   else if (paddr == `CPIF_OFF_NEXTPC)
      rdMux = nextPc_q;
   else if (paddr == `CPIF_OFF_LASTFMT)
      rdMux = {16'h0, lastFmt_q};
   else
      mapped = 1'b0;
end

always @(posedge ref_clk)
begin
   if (sys_rst)
   begin
      prdata   <= 32'h0000_0000;
      opmode_q <= `CPIF_RST_OPMODE;
      instr_q  <= `CPIF_RST_ADDR;
      ea_q     <= `CPIF_RST_ADDR;
   end
   else
   begin
      if (apbSetup)
         prdata <= rdMux;
      if (apbWr && idle && paddr == `CPIF_OFF_OPMODE)
         opmode_q <= pwdata[2:0];
      if (apbWr && idle && paddr == `CPIF_OFF_INSTR)
         instr_q <= pwdata;
      if (apbWr && idle && paddr == `CPIF_OFF_EA)
         ea_q <= pwdata;
   end
end

////////////////////////////////////////////////////////////////////////////////
// format words come from memory in S_RMFMT, from the COPROC_INTERFACE_REGISTER otherwise
assign decIn = (state_q == S_RMFMT) ? memRdata[31:16] : cirRdata[15:0];

cpif_fmt_decode uDec
(
   .fmtWord    (decIn),
   .opmode     (opmode_q),
   .isEmpty    (isEmpty),
   .isNotReady (isNotReady),
   .isInvalid  (isInvalid),
   .isValid    (isValid),
   .lenOk      (lenOk),
   .opmodeOk   (opmodeOk),
   .opWords    (opWords)
);

assign cirReq = (state_q == S_WCOND) | (state_q == S_RRESP) | (state_q == S_WOPX)
              | (state_q == S_SRD)   | (state_q == S_SROP)  | (state_q == S_RWFMT)
              | (state_q == S_RRD)   | (state_q == S_RWOP)  | (state_q == S_ABORT);
assign memReq = (state_q == S_FETCHC) | (state_q == S_FETCHX) | (state_q == S_SWFMT)
              | (state_q == S_SWMEM)  | (state_q == S_RMFMT)  | (state_q == S_RMRD);
assign irqService = (state_q == S_SIRQ);

////////////////////////////////////////////////////////////////////////////////
always @(posedge ref_clk)
begin
   if (sys_rst)
   begin
      state_q     <= S_IDLE;
      cirWrite    <= 1'b0;
      cirSel      <= `CPIF_CIR_RESP;
      cirWdata    <= 32'h0000_0000;
      memWrite    <= 1'b0;
      memLong     <= 1'b0;
      memAddr     <= 32'h0000_0000;
      memWdata    <= 32'h0000_0000;
      trapStart   <= 1'b0;
      fmtErrStart <= 1'b0;
      nextPc_q    <= 32'h0000_0000;
      lastFmt_q   <= 16'h0000;
      addr_q      <= 32'h0000_0000;
      scan_q      <= 32'h0000_0000;
      cnt_q       <= 6'h00;
      opWords_q   <= 2'h0;
      emptyHit_q  <= 1'b0;
      done_q      <= 1'b0;
      trap_q      <= 1'b0;
      badOp_q     <= 1'b0;
      fmtErr_q    <= 1'b0;
      empty_q     <= 1'b0;
   end
   else
   begin
      trapStart   <= 1'b0;
      fmtErrStart <= 1'b0;
      case (state_q)
         S_IDLE:
         begin
            if (startTrap || startSave || startRest)
            begin
               done_q   <= 1'b0;
               trap_q   <= 1'b0;
               badOp_q  <= 1'b0;
               fmtErr_q <= 1'b0;
               empty_q  <= 1'b0;
            end
            if (startTrap && !opmodeOk)
            begin
               badOp_q <= 1'b1;
               done_q  <= 1'b1;
            end
            else if (startTrap)
            begin
               opWords_q <= opWords;
               memAddr   <= instr_q;
               memLong   <= 1'b0;
               memWrite  <= 1'b0;
               state_q   <= S_FETCHC;
            end
            else if (startSave)
            begin
               cirSel   <= `CPIF_CIR_SAVE;
               cirWrite <= 1'b0;
               state_q  <= S_SRD;
            end
            else if (startRest)
            begin
               memAddr  <= ea_q;
               memLong  <= 1'b1;
               memWrite <= 1'b0;
               state_q  <= S_RMFMT;
            end
         end
         S_FETCHC:
            if (memAck)
            begin
               cirWdata <= {26'h0, memRdata[`CPIF_SEL_WIDTH-1:0]};
               cirSel   <= `CPIF_CIR_COND;
               cirWrite <= 1'b1;
               scan_q   <= instr_q + 32'h0000_0002;
               state_q  <= S_WCOND;
            end
         S_WCOND, S_WOPX:
            if (cirAck)
            begin
               cirSel   <= `CPIF_CIR_RESP;
               cirWrite <= 1'b0;
               state_q  <= S_RRESP;
            end
         S_RRESP:
            if (cirAck)
            begin
               if (cirRdata[1:0] == `CPIF_RSP_SUPPLY)
               begin
                  memAddr <= scan_q;
                  state_q <= S_FETCHX;
               end
               else if (cirRdata[1:0] != `CPIF_RSP_NULL)
               begin
                  // operand words are stepped over, never read
                  nextPc_q  <= scan_q + {29'h0, opWords_q, 1'b0};
                  trapStart <= (cirRdata[1:0] == `CPIF_RSP_TRUE);
                  trap_q    <= (cirRdata[1:0] == `CPIF_RSP_TRUE);
                  done_q    <= 1'b1;
                  state_q   <= S_IDLE;
               end
            end
         S_FETCHX:
            if (memAck)
            begin
               cirWdata <= {16'h0, memRdata[15:0]};
               cirSel   <= `CPIF_CIR_OPER;
               cirWrite <= 1'b1;
               scan_q   <= scan_q + 32'h0000_0002;
               state_q  <= S_WOPX;
            end
         S_SRD:
            if (cirAck)
            begin
               lastFmt_q <= cirRdata[15:0];
               if (isNotReady)
                  state_q <= S_SIRQ;
               else if (isInvalid || (isValid && !lenOk))
               begin
                  cirSel   <= `CPIF_CIR_CTRL;
                  cirWrite <= 1'b1;
                  cirWdata <= `CPIF_ABORT_MASK;
                  state_q  <= S_ABORT;
               end
               else
               begin
                  // format word and padding half go out as one longword
                  memAddr    <= ea_q;
                  memWdata   <= {cirRdata[15:0], 16'h0000};
                  memWrite   <= 1'b1;
                  memLong    <= 1'b1;
                  emptyHit_q <= isEmpty;
                  cnt_q      <= isEmpty ? 6'h00 : cirRdata[7:2];
                  addr_q     <= ea_q + {24'h0, cirRdata[7:2], 2'h0};
                  state_q    <= S_SWFMT;
               end
            end
         S_SIRQ:
            if (irqDone)
            begin
               cirSel  <= `CPIF_CIR_SAVE;
               state_q <= S_SRD;
            end
         S_SWFMT:
            if (memAck)
            begin
               if (emptyHit_q || cnt_q == 6'h00)
               begin
                  empty_q <= emptyHit_q;
                  done_q  <= 1'b1;
                  state_q <= S_IDLE;
               end
               else
               begin
                  cirSel   <= `CPIF_CIR_OPER;
                  cirWrite <= 1'b0;
                  state_q  <= S_SROP;
               end
            end
         S_SROP:
            if (cirAck)
            begin
               memWdata <= cirRdata;
               memAddr  <= addr_q;
               state_q  <= S_SWMEM;
            end
         S_SWMEM:
            if (memAck)
            begin
               cnt_q  <= cnt_q - 6'h01;
               addr_q <= addr_q - 32'h0000_0004;
               if (cnt_q == 6'h01)
               begin
                  done_q  <= 1'b1;
                  state_q <= S_IDLE;
               end
               else
                  state_q <= S_SROP;
            end
         S_RMFMT:
            if (memAck)
            begin
               lastFmt_q <= memRdata[31:16];
               if (isInvalid || (isValid && !lenOk))
               begin
                  cirSel   <= `CPIF_CIR_CTRL;
                  cirWrite <= 1'b1;
                  cirWdata <= `CPIF_ABORT_MASK;
                  state_q  <= S_ABORT;
               end
               else
               begin
                  cirWdata   <= {16'h0, memRdata[31:16]};
                  cirSel     <= `CPIF_CIR_RESTORE;
                  cirWrite   <= 1'b1;
                  emptyHit_q <= isEmpty;
                  cnt_q      <= isValid ? memRdata[23:18] : 6'h00;
                  addr_q     <= ea_q + 32'h0000_0004;
                  state_q    <= S_RWFMT;
               end
            end
         S_RWFMT:
            if (cirAck)
            begin
               cirWrite <= 1'b0;
               state_q  <= S_RRD;
            end
         S_RRD:
            if (cirAck)
            begin
               // not ready here is simply reread, no interrupt service
               if (isInvalid)
               begin
                  cirSel   <= `CPIF_CIR_CTRL;
                  cirWrite <= 1'b1;
                  cirWdata <= `CPIF_ABORT_MASK;
                  state_q  <= S_ABORT;
               end
               else if (isEmpty || (!isNotReady && cnt_q == 6'h00))
               begin
                  empty_q <= isEmpty & emptyHit_q;
                  done_q  <= 1'b1;
                  state_q <= S_IDLE;
               end
               else if (!isNotReady)
               begin
                  memAddr  <= addr_q;
                  memWrite <= 1'b0;
                  state_q  <= S_RMRD;
               end
            end
         S_RMRD:
            if (memAck)
            begin
               cirWdata <= memRdata;
               cirSel   <= `CPIF_CIR_OPER;
               cirWrite <= 1'b1;
               addr_q   <= addr_q + 32'h0000_0004;
               state_q  <= S_RWOP;
            end
         S_RWOP:
            if (cirAck)
            begin
               cnt_q <= cnt_q - 6'h01;
               if (cnt_q == 6'h01)
               begin
                  done_q  <= 1'b1;
                  state_q <= S_IDLE;
               end
               else
               begin
                  memAddr <= addr_q;
                  state_q <= S_RMRD;
               end
            end
         S_ABORT:
            if (cirAck)
            begin
               fmtErrStart <= 1'b1;
               fmtErr_q    <= 1'b1;
               done_q      <= 1'b1;
               state_q     <= S_IDLE;
            end
         default:
            state_q <= S_IDLE;
      endcase
   end
end

endmodule // cpif_core

// ===== cpif_regs.vh
// constants of the coprocessor trap and context frame sequencer
// assumes one 100 MHz clock, APB register access, same-clock COPROC_INTERFACE_REGISTER and memory ports
//
// Contract
// - condition word carries a six-bit selector; upper ten bits sent as zero.
// - extension words sit right after the selector word in the stream.
// - opmode 010 is one operand word, 011 two, 100 none; others invalid.
// - operand words follow the extensions and are skipped, not used.
// - after the selector write, read the response register and service requests.
// - true indicator starts trap processing; false moves to the next instruction.
// - save and restore exchange status only through format words.
// - save stores format word at address, then longwords descending from address plus length.
// - restore reads the frame at ascending addresses from the effective address.
// - format word goes first at the lowest address, followed by a padding word.
// - code 00 empty, 01 not ready, 02 invalid, 10 to FF valid frames.
// - reserved codes 03 to 0F are handled as invalid format words.
// - upper byte is the code, lower byte the frame length in bytes.
// - empty word at save start is stored alone, then the next instruction.
// - empty restore word is written, read back; echoed empty ends the restore.
// - save after empty restore returns empty; frame is format word plus padding.
// - not ready on save services interrupts, then rereads the save register.
// - invalid word from restore register sets abort and raises a format error.
// - valid word with length not a multiple of four aborts with a format error.
`ifndef CPIF_REGS_VH
`define CPIF_REGS_VH

// apb register byte offsets
`define CPIF_OFF_CMD       8'h00
`define CPIF_OFF_OPMODE    8'h04
`define CPIF_OFF_INSTR     8'h08
`define CPIF_OFF_EA        8'h0C
`define CPIF_OFF_STATUS    8'h10
`define CPIF_OFF_NEXTPC    8'h14
`define CPIF_OFF_LASTFMT   8'h18

// command bits
`define CPIF_CMD_TRAP      0
`define CPIF_CMD_SAVE      1
`define CPIF_CMD_RESTORE   2

// status bits
`define CPIF_ST_BUSY       0
`define CPIF_ST_DONE       1
`define CPIF_ST_TRAP       2
`define CPIF_ST_BADOP      3
`define CPIF_ST_FMTERR     4
`define CPIF_ST_EMPTY      5

// reset values
`define CPIF_RST_OPMODE    3'h4
`define CPIF_RST_ADDR      32'h0000_0000

// interface register selects
`define CPIF_CIR_RESP      3'h0
`define CPIF_CIR_CTRL      3'h1
`define CPIF_CIR_SAVE      3'h2
`define CPIF_CIR_RESTORE   3'h3
`define CPIF_CIR_OPER      3'h4
`define CPIF_CIR_COND      3'h5

// response codes in bits 1..0 of the response register
`define CPIF_RSP_FALSE     2'h0
`define CPIF_RSP_TRUE      2'h1
`define CPIF_RSP_SUPPLY    2'h2
`define CPIF_RSP_NULL      2'h3

// format codes and field layout
`define CPIF_FMT_EMPTY     8'h00
`define CPIF_FMT_NOTREADY  8'h01
`define CPIF_FMT_INVALID   8'h02
`define CPIF_FMT_VALIDMIN  8'h10
`define CPIF_FMT_CODE_HI   15
`define CPIF_FMT_CODE_LO   8
`define CPIF_SEL_WIDTH     6

// opmode encodings
`define CPIF_OPM_ONE       3'h2
`define CPIF_OPM_TWO       3'h3
`define CPIF_OPM_NONE      3'h4

`define CPIF_ABORT_MASK    32'h0000_0001

`endif

// ===== cpif_fmt_decode.v
// format word and opmode decoder
// assumes the caller picks the word source; purely combinational
`timescale 1ns/1ps
`include "cpif_regs.vh"

module cpif_fmt_decode
(
   input  wire [15:0] fmtWord,
   input  wire [2:0]  opmode,
   output wire        isEmpty,
   output wire        isNotReady,
   output wire        isInvalid,
   output wire        isValid,
   output wire        lenOk,
   output reg         opmodeOk,
   output reg  [1:0]  opWords
);

wire [7:0] code;

assign code       = fmtWord[`CPIF_FMT_CODE_HI:`CPIF_FMT_CODE_LO];
assign isEmpty    = (code == `CPIF_FMT_EMPTY);
assign isNotReady = (code == `CPIF_FMT_NOTREADY);
// reserved codes fold into invalid
assign isInvalid  = (code >= `CPIF_FMT_INVALID) && (code < `CPIF_FMT_VALIDMIN);
assign isValid    = (code >= `CPIF_FMT_VALIDMIN);
assign lenOk      = (fmtWord[1:0] == 2'h0);

always @*
begin
   opmodeOk = 1'b1;
   opWords  = 2'h0;
   case (opmode)
      `CPIF_OPM_ONE:  opWords = 2'h1;
      `CPIF_OPM_TWO:  opWords = 2'h2;
      `CPIF_OPM_NONE: opWords = 2'h0;
      default:        opmodeOk = 1'b0;
   endcase
end

endmodule // cpif_fmt_decode

// ===== cpif_core_asserts.sv
// port assertions for cpif_core
// assumes one clock domain; bound to cpif_core at the foot
`timescale 1ns/1ps
module cpif_core_asserts
(
   input wire        ref_clk,
   input wire        sys_rst,
   input wire        cirReq,
   input wire        cirWrite,
   input wire [2:0]  cirSel,
   input wire [31:0] cirWdata,
   input wire        cirAck,
   input wire [31:0] cirRdata,
   input wire        memReq,
   input wire        memWrite,
   input wire [31:0] memWdata,
   input wire        irqService,
   input wire        trapStart,
   input wire        fmtErrStart
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   wire       rd = cirReq && cirAck && !cirWrite;
   wire [7:0] fc = cirRdata[15:8];
   wire       ab = cirReq && cirWrite && cirSel == 3'h1 && cirWdata == 32'h1;
   //////////////////////////////////////////////////
   a_cond_upper_zero: assert property (cirReq && cirWrite && cirSel == 3'h5
      |-> cirWdata[31:6] == 26'h0) else $error("cond word upper bits set");
   a_true_traps: assert property (rd && cirSel == 3'h0 && cirRdata[1:0] == 2'h1
      |=> trapStart) else $error("true answer without trap");
   a_false_no_trap: assert property (rd && cirSel == 3'h0 && cirRdata[1:0] == 2'h0
      |=> !trapStart [*3]) else $error("false answer trapped");
   a_empty_save_store: assert property (rd && cirSel == 3'h2 && fc == 8'h00
      |-> ##[1:6] memReq && memWrite && memWdata == 32'h0) else $error("empty not stored");
   a_notready_irq: assert property (rd && cirSel == 3'h2 && fc == 8'h01
      |=> irqService) else $error("no service wait");
   a_bad_restore_abort: assert property (rd && cirSel == 3'h3 && fc > 8'h01 && fc < 8'h10
      |-> ##[1:6] ab) else $error("invalid restore not aborted");
   a_bad_len_abort: assert property (rd && cirSel == 3'h2 && fc > 8'h0F && cirRdata[1:0] != 2'h0
      |-> ##[1:6] ab) else $error("bad length not aborted");
   // the written word, not the stale read bus, names the empty frame
   a_empty_echo_read: assert property (cirReq && cirAck && cirWrite && cirSel == 3'h3
      && cirWdata[15:8] == 8'h00 |-> ##[1:6] cirReq && !cirWrite && cirSel == 3'h3)
      else $error("no readback");
   a_abort_fmterr: assert property (cirReq && cirAck && cirWrite && cirSel == 3'h1
      |=> fmtErrStart) else $error("abort without format error");
   cover property (trapStart);
   cover property (fmtErrStart);
   cover property (irqService);
endmodule // cpif_core_asserts
bind cpif_core cpif_core_asserts u_cpif_core_asserts (.*);

// ===== cpif_cpm.sv
// coprocessor and memory model on the far side of cpif_core
// assumes the same clock; slow makes cirAck and memAck answer one cycle in four, irqDone still the next cycle
`timescale 1ns/1ps
module cpif_cpm
(
   input  wire        ref_clk,
   input  wire        sys_rst,
   input  wire        slow,
   input  wire        supN,
   input  wire [1:0]  respF,
   input  wire        nrOnce,
   input  wire [15:0] saveFmt,
   input  wire        cirReq,
   input  wire        cirWrite,
   input  wire [2:0]  cirSel,
   input  wire [31:0] cirWdata,
   output reg         cirAck = 1'b0,
   output wire [31:0] cirRdata,
   input  wire        memReq,
   input  wire        memWrite,
   input  wire        memLong,
   input  wire [31:0] memAddr,
   input  wire [31:0] memWdata,
   output reg         memAck = 1'b0,
   output wire [31:0] memRdata,
   input  wire        irqService,
   output reg         irqDone = 1'b0
);
   reg  [31:0] mem [0:63];
   reg  [15:0] op_q, rw_q;
   reg  [1:0]  cnt_q;
   reg         sup_q, nr_q, empty_q;
   wire        go = !slow || cnt_q == 2'h3;
   wire        tk = cirReq && cirAck;
   wire [5:0]  mi = memAddr[7:2];
   wire [31:0] mv = memLong ? mem[mi] : {16'h0, memAddr[1] ? mem[mi][15:0] : mem[mi][31:16]};
   wire [31:0] cv = cirSel == 3'h0 ? {30'h0, supN && !sup_q ? 2'h2 : respF} :
      cirSel == 3'h2 ? {16'h0, nrOnce && !nr_q ? 16'h0100 : empty_q ? 16'h0 : saveFmt} :
      cirSel == 3'h3 ? {16'h0, rw_q[15:8] == 8'hFF ? 16'h0200 : rw_q} : {16'hC0DE, op_q};
   // released lines read inverted so a stale value cannot match
   assign cirRdata = cirAck ? cv : ~cv;
   assign memRdata = memAck ? mv : ~mv;
   always @(posedge ref_clk)
      if (sys_rst)
      begin
         {cnt_q, cirAck, memAck, irqDone, sup_q, nr_q, op_q, rw_q} <= 39'h0;
         empty_q <= 1'b1;
      end
      else
      begin
         cnt_q <= cnt_q + 2'h1;
         cirAck <= cirReq && !cirAck && go;
         memAck <= memReq && !memAck && go;
         irqDone <= irqService && !irqDone;
         if (memReq && memAck && memWrite && memLong)
            mem[mi] <= memWdata;
         if (tk && !cirWrite && cirSel == 3'h0 && supN)
            sup_q <= !sup_q;
         if (tk && !cirWrite && cirSel == 3'h2 && nrOnce)
            nr_q <= !nr_q;
         if (tk && !cirWrite && cirSel == 3'h4)
            op_q <= op_q + 16'h1;
         if (tk && cirWrite && cirSel == 3'h3)
            {rw_q, empty_q} <= {cirWdata[15:0], cirWdata[15:8] == 8'h00};
         if (tk && cirWrite && cirSel == 3'h5)
            empty_q <= 1'b0;
      end
endmodule // cpif_cpm

// ===== test_cpif_core.sv
// self-checking bench for cpif_core with the cpif_cpm far side
// assumes cpif_core_asserts is compiled alongside and bound
`timescale 1ns/1ps
module test_cpif_core;
   reg         ref_clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg         supN = 1'b0, nrOnce = 1'b0, slow = 1'b0, e;
   reg  [1:0]  respF = 2'h0;
   reg  [7:0]  paddr = 8'h00;
   reg  [15:0] saveFmt = 16'h0000;
   reg  [31:0] pwdata = 32'h0, r, s, x, cq, seed = 32'h000038AB;
   reg  [31:0] wq[$], rq[$];
   wire        pready, pslverr, cirReq, cirWrite, cirAck, memReq, memWrite, memLong, memAck;
   wire        irqService, irqDone, trapStart, fmtErrStart;
   wire [2:0]  cirSel;
   wire [31:0] prdata, cirWdata, cirRdata, memAddr, memWdata, memRdata;
   integer     t, b, i, n_errors = 0, cmp_count = 0;
   cpif_core u_cpif_core (.*);
   cpif_cpm u_cpif_cpm (.*);
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
      if (cirReq && cirAck && cirSel == 3'h5)
         cq <= cirWdata;
      else if (cirReq && cirAck && cirSel == 3'h4 && cirWrite)
         wq.push_back(cirWdata);
      else if (cirReq && cirAck && cirSel == 3'h4)
         rq.push_back(cirRdata);
   //////////////////////////////////////////////////
   function logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function logic [31:0] stat(input integer m, input logic tr);
      return (m < 2 || m > 4) ? 32'hA : tr ? 32'h6 : 32'h2;
   endfunction
   function logic [31:0] npc(input integer m, input logic sup);
      return 32'hC4 + 2 * sup + (m == 2 ? 2 : m == 3 ? 4 : 0);
   endfunction
   task report_and_stop;
      $display("mismatches %0d compares %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task tmo;
      $display("Error %0t: no answer", $time);
      n_errors++;
      report_and_stop;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] w);
      cmp_count++;
      if (g !== w)
      begin
         n_errors++;
         $display("Error %0t: got %h want %h", $time, g, w);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge ref_clk);
      penable <= 1'b1;
      for (i = 0; i < 40 && pready !== 1'b1; i++) @(posedge ref_clk);
      if (pready !== 1'b1)
         tmo;
      {r, e} = {prdata, pslverr};
      {psel, penable} <= 2'h0;
   endtask
   // polls status; done with busy low ends the wait
   task run(input logic [2:0] c, input logic [31:0] w);
      integer k;
      apb(1'b1, 8'h00, {29'h0, c});
      r = 32'h0;
      for (k = 0; k < 60 && r[1:0] !== 2'h2; k++) apb(1'b0, 8'h10, 32'h0);
      if (r[1:0] !== 2'h2)
         tmo;
      chk(r, w);
   endtask
   //////////////////////////////////////////////////
   initial
   begin
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      apb(1'b0, 8'h04, 32'h0);
      chk(r, 32'h4);
      apb(1'b0, 8'h1C, 32'h0);
      chk({31'h0, e}, 32'h1);
      b = xs() & 32'h1F;
      apb(1'b1, 8'h0C, b * 4);
      u_cpif_cpm.mem[b] = 32'hFFFF_FFFF;
      run(3'h2, 32'h22);
      chk(u_cpif_cpm.mem[b], 32'h0);
      apb(1'b1, 8'h08, 32'hC2);
      for (t = 0; t < 16; t++)
      begin
         s = xs();
         x = xs();
         {supN, respF, slow} <= {s[16], 1'b0, s[17], s[18]};
         u_cpif_cpm.mem[8'h30] = s;
         u_cpif_cpm.mem[8'h31] = x;
         wq.delete();
         apb(1'b1, 8'h04, t % 8);
         run(3'h1, stat(t % 8, s[17]));
         apb(1'b0, 8'h14, 32'h0);
         if (t % 8 > 1 && t % 8 < 5)
         begin
            chk(r, npc(t % 8, s[16]));
            chk(cq, {26'h0, s[5:0]});
            if (s[16])
               chk({16'h0, wq[0][15:0]}, {16'h0, x[31:16]});
         end
      end
      {saveFmt, nrOnce, supN} <= {16'h1008, 2'h2};
      rq.delete();
      u_cpif_cpm.mem[b + 3] = 32'h5A5A_5A5A;
      run(3'h2, 32'h2);
      chk(u_cpif_cpm.mem[b], 32'h1008_0000);
      chk(u_cpif_cpm.mem[b + 2], rq[0]);
      chk(u_cpif_cpm.mem[b + 1], rq[1]);
      chk(u_cpif_cpm.mem[b + 3], 32'h5A5A_5A5A);
      nrOnce <= 1'b0;
      for (t = 0; t < 3; t++)
      begin
         saveFmt <= t == 0 ? 16'h1006 : t == 1 ? 16'h0200 : 16'h0F40;
         run(3'h2, 32'h12);
      end
      u_cpif_cpm.mem[b] = 32'h1008_0000;
      u_cpif_cpm.mem[b + 1] = xs();
      u_cpif_cpm.mem[b + 2] = xs();
      wq.delete();
      run(3'h4, 32'h2);
      chk(wq[0], u_cpif_cpm.mem[b + 1]);
      chk(wq[1], u_cpif_cpm.mem[b + 2]);
      u_cpif_cpm.mem[b] = 32'h0;
      run(3'h4, 32'h22);
      saveFmt <= 16'h1008;
      u_cpif_cpm.mem[b + 1] = 32'h5A5A_5A5A;
      run(3'h2, 32'h22);
      chk(u_cpif_cpm.mem[b + 1], 32'h5A5A_5A5A);
      for (t = 0; t < 2; t++)
      begin
         u_cpif_cpm.mem[b] = t ? 32'hFF04_0000 : 32'h0500_0000;
         run(3'h4, 32'h12);
      end
      report_and_stop;
   end
endmodule // test_cpif_core
